// ==== eeprom_reader_model.sv ====
/*
  eeprom reader model: answers a held fetch request with a one-cycle ack carrying the word.
  assumes the fetch request is a registered level on the same clock as the register bank.
*/
module eeprom_reader_model #(
  parameter logic [15:0] WORD  = 16'h1234, // arbitrary stored identifier
  parameter int          DELAY = 8         // cycles of fetch latency
) (
  input  wire logic        MCLK,    // core clock
  input  wire logic        RST_N,   // channel reset, active low
  input  wire logic        EE_REQ,  // fetch request
  output logic             EE_ACK,  // word valid
  output logic [15:0]      EE_DATA  // word; toggles outside the ack
);
  timeunit 1ns;
  timeprecision 1ps;
  int  cnt;
  wire fire = EE_REQ && !EE_ACK && cnt == DELAY;
  // data toggles when not acked, so a late sample cannot pass by luck
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt <= 0;
      EE_ACK <= 1'b0;
      EE_DATA <= ~WORD;
    end else begin
      EE_ACK <= fire;
      EE_DATA <= fire ? WORD : ~EE_DATA;
      cnt <= (EE_REQ && !EE_ACK && cnt < DELAY) ? cnt + 1 : 0;
    end
  end
endmodule // eeprom_reader_model

// ==== id_loader.sv ====
/*
  auto-initialisation sequencer: fetches the 16-bit adapter identifier from the
  eeprom reader. assumes the reader sits on the same clock and answers a held
  request with a one-cycle ack carrying the data.
*/
module id_loader (
  input  wire logic        clk,      // core clock
  input  wire logic        rst_n,    // synchronised reset, active low
  input  wire logic        restart,  // any reload reset, level
  input  wire logic        ee_ack,   // eeprom word valid
  input  wire logic [15:0] ee_data,  // eeprom word
  output logic             ee_req,   // fetch request, registered
  output logic [15:0]      id_q,     // loaded identifier
  output logic             done      // auto-init finished
);
  typedef enum logic {LD_FETCH, LD_DONE} ld_e;
  ld_e         st_q, st_d;
  logic [15:0] id_d;
  logic        req_d;

  always_comb begin
    st_d  = st_q;
    id_d  = id_q;
    if (restart) begin
      st_d = LD_FETCH;  // [R03]
    end else begin
      case (st_q)
        LD_FETCH: begin
          if (ee_ack) begin
            id_d = ee_data;  // [R03]
            st_d = LD_DONE;
          end
        end
        LD_DONE: st_d = LD_DONE;
        default: st_d = LD_FETCH;
      endcase
    end
    req_d = (st_d == LD_FETCH);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= LD_FETCH;
      id_q   <= 16'h0000;
      ee_req <= 1'b1;
    end else begin
      st_q   <= st_d;
      id_q   <= id_d;
      ee_req <= req_d;
    end
  end

  assign done = (st_q == LD_DONE);

  chk_reload_clears: assert property (@(posedge clk) disable iff (!rst_n) // [R03]
    restart |=> !done && ee_req) else $error("reload reset did not restart fetch");
  chk_reload_captures: assert property (@(posedge clk) disable iff (!rst_n) // [R03]
    (!restart && !done && ee_ack) |=> done && id_q == $past(ee_data))
    else $error("identifier not captured on ack");
endmodule // id_loader

// ==== pos_cfg_pkg.sv ====
/*
  constants for the option-select register bank: register indices, field layout,
  reset values and boot window geometry.
  assumes it is compiled before every design file that imports it.
*/
// Function
// R01 - writes only during setup cycles to card
// R02 - all bits readable through setup window zero
// R03 - reload identifier from eeprom on resets
// R04 - identifier reads zero before auto-init done
// R05 - test mode forces fixed identifier
// R06 - identifier shown as two bytes
// R07 - card disabled ignores all but setup
// R08 - card disabled: no dma, no interrupts
// R09 - configuration program must set enable
// R10 - test mode acts as card enabled
// R11 - size selects 8k, 16k or 32k
// R12 - channel reset clears boot rom base
// R13 - base zero disables; size 00 8k steps
// R14 - size 01 ignores base bit0, 16k
// R15 - unlisted size/base combos decode nothing
package pos_cfg_pkg;
  localparam int unsigned ADDR_W       = 2;
  localparam logic [1:0]  IDX_ID_LO    = 2'h0;
  localparam logic [1:0]  IDX_ID_HI    = 2'h1;
  localparam logic [1:0]  IDX_CARD_EN  = 2'h2;
  localparam logic [1:0]  IDX_ROM_SEL  = 2'h3;
  localparam int unsigned CARD_ENABLE_BIT_BIT     = 0;
  localparam int unsigned BASE_LSB     = 0;
  localparam int unsigned SIZE_LSB     = 4;
  localparam logic [7:0]  CARD_EN_RST  = 8'h00;
  localparam logic [7:0]  ROM_SEL_RST  = 8'h00;
  localparam logic [7:0]  ROM_SEL_MASK = 8'h3F;
  localparam logic [15:0] ID_HIDDEN    = 16'h0000;
  // size field encodings; 32k window has no listed base combination
  localparam logic [1:0]  SIZE_8K      = 2'h0;
  localparam logic [1:0]  SIZE_16K     = 2'h1;
  localparam logic [3:0]  BASE_OFF     = 4'h0;
  // boot area C0000h-DFFFFh: top three memory address bits
  localparam logic [2:0]  ROM_AREA     = 3'h6;
  // host memory address fields used by the boot window decode
  localparam int unsigned AREA_LSB     = 17;
  localparam int unsigned WIN8_LSB     = 13;
  localparam int unsigned WIN16_LSB    = 14;
endpackage

// ==== pos_cfg_regs.sv ====
/*
  option-select register bank: identifier, card enable and boot rom window.
  assumes bus strobes come from logic on MCLK; reset and test straps are
  asynchronous pins and are synchronised here.
*/
module pos_cfg_regs
  import pos_cfg_pkg::*;
#(
  parameter logic [15:0] TEST_ID = 16'hA5A5  // arbitrary value
) (
  input  wire logic                       MCLK,         // 40 MHz core clock
  input  wire logic                       RST_N,        // channel reset, active low
  input  wire logic                       CFG_RST,      // card_config_reset pin
  input  wire logic                       LOWPWR_RST,   // low-power reset pin
  input  wire logic                       AUTOINIT_RST, // auto_init_state_machine reset pin
  input  wire logic                       TEST_MODE,    // test mode strap
  input  wire logic                       SETUP_SEL,    // setup cycle selecting this card
  input  wire logic                       WR_STB,       // register write strobe
  input  wire logic                       RD_STB,       // register read strobe
  input  wire logic [pos_cfg_pkg::ADDR_W-1:0] REG_IDX,  // register index
  input  wire logic [7:0]                 WDATA,        // write data
  output logic      [7:0]                 RDATA,        // read data
  input  wire logic                       EE_ACK,       // eeprom word valid
  input  wire logic [15:0]                EE_DATA,      // eeprom word
  output logic                            EE_REQ,       // eeprom fetch request
  output logic                            CARD_ACTIVE,  // host access enabled
  input  wire logic                       DMA_REQ_IN,   // core dma request
  input  wire logic                       IRQ_IN,       // core interrupt
  output logic                            DMA_REQ_OUT,  // gated dma request
  output logic                            IRQ_OUT,      // gated interrupt
  input  wire logic                       MEM_RD,       // host memory read
  input  wire logic [19:0]                MEM_ADDR,     // host memory address
  output logic                            ROM_HIT       // boot rom claims read
);
  logic [1:0]  rst_sync_q;
  logic        rst_n_s;
  logic [3:0]  pin_raw;
  logic [3:0]  pin_m_q;
  logic [3:0]  pin_s_q;
  logic        test_s;
  logic        restart;
  logic [7:0]  card_en_q, card_en_d;
  logic [7:0]  rom_sel_q, rom_sel_d;
  logic [7:0]  rdata_d;
  logic        active_d, hit_d;
  logic [15:0] id_raw, id_view;
  logic        id_done;
  logic [1:0]  size_f;
  logic [3:0]  base_f;

  // channel reset asserts at once but leaves only on a clock edge,
  // so no register sees its release in mid-cycle
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n_s = rst_sync_q[1];

  assign pin_raw = {TEST_MODE, AUTOINIT_RST, LOWPWR_RST, CFG_RST};
  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge MCLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
        pin_m_q[i] <= 1'b0;
        pin_s_q[i] <= 1'b0;
      end else begin
        pin_m_q[i] <= pin_raw[i];
        pin_s_q[i] <= pin_m_q[i];
      end
    end
  end
  // test strap lags two cycles; the enable override follows one cycle later
  assign test_s  = pin_s_q[3];
  assign restart = |pin_s_q[2:0];  // [R03]

  id_loader u_loader (
    .clk     (MCLK),
    .rst_n   (rst_n_s),
    .restart (restart),
    .ee_ack  (EE_ACK),
    .ee_data (EE_DATA),
    .ee_req  (EE_REQ),
    .id_q    (id_raw),
    .done    (id_done)
  );

  assign size_f = rom_sel_q[SIZE_LSB +: 2];  // [R11]
  assign base_f = rom_sel_q[BASE_LSB +: 4];

  always_comb begin
    card_en_d = card_en_q;
    rom_sel_d = rom_sel_q;
    // writes outside a setup cycle are dropped without any answer
    if (SETUP_SEL && WR_STB) begin  // [R01]
      case (REG_IDX)
        IDX_CARD_EN: card_en_d = WDATA & (8'h01 << CARD_ENABLE_BIT_BIT);
        IDX_ROM_SEL: rom_sel_d = WDATA & ROM_SEL_MASK;
        default:     ;
      endcase
    end
    active_d = card_en_q[CARD_ENABLE_BIT_BIT] || test_s;  // [R10]
    if (test_s)        id_view = TEST_ID;      // [R05]
    else if (!id_done) id_view = ID_HIDDEN;    // [R04]
    else               id_view = id_raw;
    rdata_d = 8'h00;
    // reads outside setup are refused while the card is disabled
    if (RD_STB && (SETUP_SEL || active_d)) begin  // [R02] [R07]
      case (REG_IDX)
        IDX_ID_LO:   rdata_d = id_view[7:0];   // [R06]
        IDX_ID_HI:   rdata_d = id_view[15:8];  // [R06]
        IDX_CARD_EN: rdata_d = card_en_q;
        IDX_ROM_SEL: rdata_d = rom_sel_q;
        default:     rdata_d = 8'h00;
      endcase
    end
    hit_d = 1'b0;
    // a disabled card claims no boot window, so a stale base cannot shadow system memory
    if (MEM_RD && active_d && base_f != BASE_OFF && MEM_ADDR[AREA_LSB +: 3] == ROM_AREA) begin  // [R13]
      case (size_f)
        SIZE_8K:  hit_d = (MEM_ADDR[WIN8_LSB +: 4] == base_f);       // [R13]
        SIZE_16K: hit_d = (MEM_ADDR[WIN16_LSB +: 3] == base_f[3:1]); // [R14]
        default:  hit_d = 1'b0;                                 // [R15]
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      card_en_q   <= CARD_EN_RST;
      rom_sel_q   <= ROM_SEL_RST;  // [R12]
      RDATA       <= 8'h00;
      CARD_ACTIVE <= 1'b0;
      DMA_REQ_OUT <= 1'b0;
      IRQ_OUT     <= 1'b0;
      ROM_HIT     <= 1'b0;
    end else begin
      card_en_q   <= card_en_d;
      rom_sel_q   <= rom_sel_d;
      RDATA       <= rdata_d;
      CARD_ACTIVE <= active_d;
      DMA_REQ_OUT <= DMA_REQ_IN && active_d;  // [R08]
      IRQ_OUT     <= IRQ_IN && active_d;      // [R08]
      ROM_HIT     <= hit_d;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!rst_n_s);

  chk_wr_outside_setup: assert property ( // [R01]
    (WR_STB && !SETUP_SEL) |=> card_en_q == $past(card_en_q) && rom_sel_q == $past(rom_sel_q))
    else $error("register changed outside setup cycle");
  chk_rd_rom_sel: assert property ( // [R02]
    (RD_STB && SETUP_SEL && REG_IDX == IDX_ROM_SEL) |=> RDATA == $past(rom_sel_q))
    else $error("rom select readback wrong");
  chk_id_hidden: assert property ( // [R04]
    (RD_STB && SETUP_SEL && REG_IDX == IDX_ID_HI && !id_done && !test_s) |=> RDATA == 8'h00)
    else $error("identifier visible before auto-init done");
  chk_test_id: assert property ( // [R05]
    (RD_STB && SETUP_SEL && REG_IDX == IDX_ID_LO && test_s) |=> RDATA == TEST_ID[7:0])
    else $error("test identifier not forced");
  chk_disabled_read: assert property ( // [R07]
    (RD_STB && !SETUP_SEL && !card_en_q[CARD_ENABLE_BIT_BIT] && !test_s) |=> RDATA == 8'h00)
    else $error("disabled card answered host read");
  chk_dma_gate: assert property ( // [R08]
    (!card_en_q[CARD_ENABLE_BIT_BIT] && !test_s) |=> !DMA_REQ_OUT && !IRQ_OUT && !CARD_ACTIVE)
    else $error("dma or interrupt while card disabled");
  chk_test_enable: assert property ( // [R10]
    test_s |=> CARD_ACTIVE) else $error("test mode did not enable card");
  chk_rom_off: assert property ( // [R13]
    (base_f == BASE_OFF) |=> !ROM_HIT) else $error("rom hit with base zero");
  chk_rom_16k: assert property ( // [R14]
    (MEM_RD && CARD_ACTIVE && card_en_q[CARD_ENABLE_BIT_BIT] && size_f == SIZE_16K && base_f == 4'h3
     && MEM_ADDR == 20'hC_7FFF) |=> ROM_HIT) else $error("16k window at C4000h missed");
  chk_rom_unlisted: assert property ( // [R15]
    (size_f != SIZE_8K && size_f != SIZE_16K) |=> !ROM_HIT) else $error("unlisted size decoded");

  chk_wr_card_en: assert property ( // [R01]
    (SETUP_SEL && WR_STB && REG_IDX == IDX_CARD_EN) |=> card_en_q == ($past(WDATA) & (8'h01 << CARD_ENABLE_BIT_BIT)))
    else $error("card enable write lost");
  chk_wr_rom_sel: assert property ( // [R01]
    (SETUP_SEL && WR_STB && REG_IDX == IDX_ROM_SEL) |=> rom_sel_q == ($past(WDATA) & ROM_SEL_MASK))
    else $error("rom select write lost");
  chk_rd_card_en: assert property ( // [R02]
    (RD_STB && SETUP_SEL && REG_IDX == IDX_CARD_EN) |=> RDATA == $past(card_en_q))
    else $error("card enable readback wrong");
  chk_id_low_byte: assert property ( // [R06]
    (RD_STB && SETUP_SEL && REG_IDX == IDX_ID_LO && id_done && !test_s) |=> RDATA == $past(id_raw[7:0]))
    else $error("identifier low byte wrong");
  chk_id_high_byte: assert property ( // [R06]
    (RD_STB && SETUP_SEL && REG_IDX == IDX_ID_HI && id_done && !test_s) |=> RDATA == $past(id_raw[15:8]))
    else $error("identifier high byte wrong");
  chk_test_id_hi: assert property ( // [R05]
    (RD_STB && SETUP_SEL && REG_IDX == IDX_ID_HI && test_s) |=> RDATA == TEST_ID[15:8])
    else $error("test identifier high byte not forced");
  chk_dma_pass: assert property ( // [R08]
    (card_en_q[CARD_ENABLE_BIT_BIT] && DMA_REQ_IN) |=> DMA_REQ_OUT)
    else $error("enabled card dropped dma request");
  chk_irq_pass: assert property ( // [R08]
    (card_en_q[CARD_ENABLE_BIT_BIT] && IRQ_IN) |=> IRQ_OUT)
    else $error("enabled card dropped interrupt");
  chk_rom_8k_hit: assert property ( // [R13]
    (MEM_RD && card_en_q[CARD_ENABLE_BIT_BIT] && size_f == SIZE_8K && base_f == 4'h1
     && MEM_ADDR == 20'hC_2000) |=> ROM_HIT) else $error("8k window at C2000h missed");
  chk_rom_8k_miss: assert property ( // [R13]
    (MEM_RD && card_en_q[CARD_ENABLE_BIT_BIT] && size_f == SIZE_8K && base_f == 4'h1
     && MEM_ADDR == 20'hC_4000) |=> !ROM_HIT) else $error("8k window decoded outside its base");
  chk_rom_16k_base: assert property ( // [R14]
    (MEM_RD && card_en_q[CARD_ENABLE_BIT_BIT] && size_f == SIZE_16K && base_f == 4'h3
     && MEM_ADDR == 20'hC_4000) |=> ROM_HIT) else $error("16k window start at C4000h missed");
endmodule // pos_cfg_regs

// ==== pos_cfg_regs_tb_top.sv ====
/*
  self-checking bench for the option-select register bank with an eeprom reader model.
  assumes the design's registered one-cycle read answer and two-flop reset and strap syncs.
*/
module pos_cfg_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pos_cfg_pkg::*;
  localparam logic [15:0] TID = 16'h5A3C; // arbitrary test identifier
  localparam logic [15:0] EWORD = 16'h1234; // arbitrary eeprom identifier
  logic MCLK = 0, RST_N = 0, CFG_RST = 0, LOWPWR_RST = 0, AUTOINIT_RST = 0, TEST_MODE = 0;
  logic SETUP_SEL = 0, WR_STB = 0, RD_STB = 0, DMA_REQ_IN = 0, IRQ_IN = 0, MEM_RD = 0;
  logic [1:0]  REG_IDX = 2'h0;
  logic [7:0]  WDATA = 8'h00, RDATA;
  logic [15:0] EE_DATA;
  logic [19:0] MEM_ADDR = 20'h0_0000;
  logic EE_ACK, EE_REQ, CARD_ACTIVE, DMA_REQ_OUT, IRQ_OUT, ROM_HIT;
  int n_errors = 0, check_count = 0;
  always #12.5 MCLK = ~MCLK;
  pos_cfg_regs #(.TEST_ID(TID)) pos_cfg_regs_i (.MCLK(MCLK), .RST_N(RST_N), .CFG_RST(CFG_RST),
    .LOWPWR_RST(LOWPWR_RST), .AUTOINIT_RST(AUTOINIT_RST), .TEST_MODE(TEST_MODE), .SETUP_SEL(SETUP_SEL),
    .WR_STB(WR_STB), .RD_STB(RD_STB), .REG_IDX(REG_IDX), .WDATA(WDATA), .RDATA(RDATA), .EE_ACK(EE_ACK),
    .EE_DATA(EE_DATA), .EE_REQ(EE_REQ), .CARD_ACTIVE(CARD_ACTIVE), .DMA_REQ_IN(DMA_REQ_IN),
    .IRQ_IN(IRQ_IN), .DMA_REQ_OUT(DMA_REQ_OUT), .IRQ_OUT(IRQ_OUT), .MEM_RD(MEM_RD),
    .MEM_ADDR(MEM_ADDR), .ROM_HIT(ROM_HIT));
  eeprom_reader_model #(.WORD(EWORD)) eeprom_reader_model_i (.MCLK(MCLK), .RST_N(RST_N),
    .EE_REQ(EE_REQ), .EE_ACK(EE_ACK), .EE_DATA(EE_DATA));
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [1:0] idx, input logic sel, input logic [7:0] wd,
                     output logic [7:0] d);
    @(posedge MCLK);
    WR_STB <= w;
    RD_STB <= !w;
    SETUP_SEL <= sel;
    REG_IDX <= idx;
    WDATA <= wd;
    @(posedge MCLK);
    {WR_STB, RD_STB, SETUP_SEL} <= 3'b000;
    #1 d = RDATA;
  endtask
  task automatic rdid(output logic [15:0] v);
    logic [7:0] lo, hi;
    acc(0, IDX_ID_LO, 1, 8'h00, lo);
    acc(0, IDX_ID_HI, 1, 8'h00, hi);
    v = {hi, lo};
  endtask
  task automatic wait_loaded();
    int i;
    for (i = 0; i < 60 && EE_REQ !== 1'b0; i++) begin
      @(posedge MCLK);
      #1;
    end
    if (EE_REQ !== 1'b0) begin
      n_errors++;
      print_verdict();
    end
  endtask
  task automatic t_id();
    logic [15:0] v;
    rdid(v);
    chk(v, ID_HIDDEN);
    wait_loaded();
    rdid(v);
    chk(v, EWORD);
    for (int k = 0; k < 3; k++) begin
      @(posedge MCLK);
      {AUTOINIT_RST, LOWPWR_RST, CFG_RST} <= 3'b001 << k;
      repeat (4) @(posedge MCLK);
      {AUTOINIT_RST, LOWPWR_RST, CFG_RST} <= 3'b000;
      rdid(v);
      chk(v, ID_HIDDEN);
      wait_loaded();
      rdid(v);
      chk(v, EWORD);
    end
    $display("identifier test done");
  endtask
  task automatic t_en();
    logic [7:0] d;
    @(posedge MCLK);
    {DMA_REQ_IN, IRQ_IN} <= 2'b11;
    acc(0, IDX_CARD_EN, 1, 8'h00, d);
    chk(d, CARD_EN_RST);
    acc(0, IDX_ID_LO, 0, 8'h00, d);
    chk(d, 8'h00);
    acc(1, IDX_CARD_EN, 0, 8'h01, d);
    repeat (3) @(posedge MCLK);
    #1 chk({CARD_ACTIVE, DMA_REQ_OUT, IRQ_OUT}, 16'h0000);
    acc(1, IDX_CARD_EN, 1, 8'hFF, d);
    repeat (3) @(posedge MCLK);
    #1 chk({CARD_ACTIVE, DMA_REQ_OUT, IRQ_OUT}, 16'h0007);
    acc(0, IDX_ID_HI, 0, 8'h00, d);
    chk(d, EWORD[15:8]);
    acc(0, IDX_CARD_EN, 0, 8'h00, d);
    chk(d, 8'h01);
    $display("card enable test done");
  endtask
  task automatic t_rom();
    logic [7:0]  d;
    logic [7:0]  sel[6] = '{8'h00, 8'h01, 8'h01, 8'hD3, 8'h13, 8'h2F};
    logic [19:0] adr[6] = '{20'hC_0000, 20'hC_2000, 20'hC_4000, 20'hC_4000, 20'hC_7FFF, 20'hD_E000};
    logic        hit[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 6; i++) begin
      acc(1, IDX_ROM_SEL, 1, sel[i], d);
      acc(0, IDX_ROM_SEL, 1, 8'h00, d);
      chk(d, sel[i] & ROM_SEL_MASK);
      @(posedge MCLK);
      MEM_RD <= 1'b1;
      MEM_ADDR <= adr[i];
      @(posedge MCLK);
      MEM_RD <= 1'b0;
      #1 chk(ROM_HIT, hit[i]);
    end
    @(posedge MCLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge MCLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge MCLK);
    acc(0, IDX_ROM_SEL, 1, 8'h00, d);
    chk(d, ROM_SEL_RST);
    $display("boot rom test done");
  endtask
  task automatic t_test();
    logic [7:0]  d;
    logic [15:0] v;
    @(posedge MCLK);
    TEST_MODE <= 1'b1;
    repeat (5) @(posedge MCLK);
    #1 chk({CARD_ACTIVE, DMA_REQ_OUT}, 16'h0003);
    rdid(v);
    chk(v, TID);
    acc(1, IDX_CARD_EN, 1, 8'h01, d);
    acc(0, IDX_CARD_EN, 1, 8'h00, d);
    chk(d, 8'h01);
    acc(1, IDX_CARD_EN, 1, 8'h00, d);
    acc(0, IDX_CARD_EN, 1, 8'h00, d);
    chk(d, 8'h00);
    #1 chk(CARD_ACTIVE, 1'b1);
    $display("test mode test done");
  endtask
  initial begin
    repeat (3) @(posedge MCLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge MCLK);
    t_id();
    t_en();
    t_rom();
    t_test();
    print_verdict();
  end
endmodule // pos_cfg_regs_tb_top
